// ==== virq_spu_pkg.sv ====
// constants for the spurious interrupt handling block
package virq_spu_pkg;
    localparam int          NUM_SRC     = 32;
    localparam int          VEC_W       = 32;
    localparam logic [31:0] SPU_RST_VAL = 32'h0000_0000;
    localparam int          FIQ_SRC     = 0;
    typedef enum logic [1:0] {
        VIRQ_IDLE = 2'b00,
        VIRQ_SERV = 2'b01,
        VIRQ_SPUR = 2'b10
    } virq_state_t;
endpackage

// ==== virq_vec_mem.sv ====
// vector memory: one word per source, registered read
`timescale 1ns/100ps
module virq_vec_mem
    import virq_spu_pkg::*;
(
    input  wire logic             i_sys_clk,
    input  wire logic             i_we,
    input  wire logic [4:0]       i_waddr,
    input  wire logic [VEC_W-1:0] i_wdata,
    input  wire logic [4:0]       i_raddr,
    output logic      [VEC_W-1:0] o_rdata
);
    logic [VEC_W-1:0] mem_q [NUM_SRC];
    logic [VEC_W-1:0] rdata_q;

    // no reset: contents are set by software at table init
    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
        rdata_q <= mem_q[i_raddr];
    end

    assign o_rdata = rdata_q;
endmodule // virq_vec_mem

// ==== virq_spu_ctrl.sv ====
// spurious interrupt detection and request gating
//
// Function
// RULE_01: a level source dropping while the core takes its request is spurious.
// RULE_02: a source asserting while software disables it is spurious.
// RULE_03: a vector read with nothing pending enters spurious handling.
// RULE_04: fast requests get the same spurious handling as normal ones.
// RULE_05: while spurious, both request outputs stay inactive until acknowledged.
// RULE_06: the core's handler must write end-of-interrupt before it returns.
// RULE_07: a spurious read returns the spurious vector as vector read data.
// RULE_08: the spurious vector lives in a software-writable register.
// RULE_09: an end-of-interrupt write clears the spurious state.
`timescale 1ns/100ps
module virq_spu_ctrl
    import virq_spu_pkg::*;
(
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst_b,
    input  wire logic [NUM_SRC-1:0] i_src,
    input  wire logic [NUM_SRC-1:0] i_src_level,
    input  wire logic               i_enable_wr,
    input  wire logic               i_disable_wr,
    input  wire logic [NUM_SRC-1:0] i_cmd_mask,
    input  wire logic               i_vec_wr,
    input  wire logic [4:0]         i_vec_idx,
    input  wire logic [VEC_W-1:0]   i_vec_data,
    input  wire logic               i_spu_wr,
    input  wire logic               i_ivr_rd,
    input  wire logic               i_fvr_rd,
    input  wire logic               i_eoi_wr,
    output logic                    o_normal_irq_out_n,
    output logic                    o_fast_irq_out_n,
    output logic [VEC_W-1:0]        o_vec_rdata,
    output logic                    o_vec_valid,
    output logic                    o_spurious,
    output logic [VEC_W-1:0]        o_spu_vec
);
    logic [NUM_SRC-1:0] src_m_q, src_s_q, src_p_q;
    logic [NUM_SRC-1:0] en_q, en_d;
    logic [NUM_SRC-1:0] pend_q, pend_d;
    logic [NUM_SRC-1:0] act;
    virq_state_t        st_q, st_d;
    logic [VEC_W-1:0]   spu_q, spu_d;
    logic               normal_irq_out_n_q, normal_irq_out_n_d, fast_irq_out_n_q, fast_irq_out_n_d;
    logic               rd_q, spur_rd_q, spur_q;
    logic [4:0]         cur_q, cur_d, hit;
    logic               any_irq, any_fiq;
    logic [VEC_W-1:0]   mem_rd;

    function automatic logic [4:0] top_src(input logic [NUM_SRC-1:0] v);
        logic [4:0] r;
        r = '0;
        for (int k = 0; k < NUM_SRC; k++) begin
            if (v[k]) begin
                r = 5'(k);
            end
        end
        return r;
    endfunction

    // pins are asynchronous: two flops before use
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            src_m_q <= '0;
            src_s_q <= '0;
            src_p_q <= '0;
        end else begin
            src_m_q <= i_src;
            src_s_q <= src_m_q;
            src_p_q <= src_s_q;
        end
    end

    virq_vec_mem u_mem (
        .i_sys_clk (i_sys_clk),
        .i_we      (i_vec_wr),
        .i_waddr   (i_vec_idx),
        .i_wdata   (i_vec_data),
        .i_raddr   (cur_d),
        .o_rdata   (mem_rd)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            // level sources follow the pin; edge sources latch until served
            always_comb begin
                pend_d[g] = i_src_level[g] ? src_s_q[g]
                          : (pend_q[g] | (src_s_q[g] & ~src_p_q[g]));
                if (i_src_level[g] == 1'b0 && rd_q && cur_q == 5'(g)
                    && !spur_rd_q) begin
                    pend_d[g] = src_s_q[g] & ~src_p_q[g];
                end
            end
        end
    endgenerate

    assign act     = pend_q & en_q;
    assign any_fiq = act[FIQ_SRC];
    assign any_irq = |(act & ~NUM_SRC'(1));
    assign hit     = top_src(act & ~NUM_SRC'(1));

    always_comb begin
        en_d  = en_q;
        spu_d = spu_q;
        st_d  = st_q;
        cur_d = cur_q;
        if (i_enable_wr) begin
            en_d = en_d | i_cmd_mask;
        end
        if (i_disable_wr) begin
            en_d = en_d & ~i_cmd_mask;
        end
        if (i_spu_wr) begin
            spu_d = i_vec_data; // [RULE_08]
        end
        unique case (st_q)
            VIRQ_IDLE: begin
                if (i_fvr_rd) begin
                    // fast path: nothing pending means spurious too
                    st_d  = any_fiq ? VIRQ_SERV : VIRQ_SPUR; // [RULE_04]
                    cur_d = 5'(FIQ_SRC);
                end else if (i_ivr_rd) begin
                    // a withdrawn level or a just-disabled source both leave
                    // nothing active here, so one test covers all three cases
                    st_d  = any_irq ? VIRQ_SERV : VIRQ_SPUR; // [RULE_01] [RULE_02] [RULE_03]
                    cur_d = hit;
                end
            end
            VIRQ_SERV: begin
                if (i_eoi_wr) begin
                    st_d = VIRQ_IDLE;
                end
            end
            VIRQ_SPUR: begin
                // handler's end-of-interrupt write is the only way out
                if (i_eoi_wr) begin
                    st_d = VIRQ_IDLE; // [RULE_06] [RULE_09]
                end
            end
            default: st_d = VIRQ_IDLE;
        endcase
        normal_irq_out_n_d = !(st_q == VIRQ_IDLE && st_d == VIRQ_IDLE && any_irq); // [RULE_05]
        fast_irq_out_n_d = !(st_q != VIRQ_SPUR && st_d != VIRQ_SPUR && any_fiq); // [RULE_05]
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            en_q      <= '0;
            pend_q    <= '0;
            spu_q     <= SPU_RST_VAL;
            st_q      <= VIRQ_IDLE;
            cur_q     <= '0;
            normal_irq_out_n_q    <= 1'b1;
            fast_irq_out_n_q    <= 1'b1;
            rd_q      <= 1'b0;
            spur_rd_q <= 1'b0;
            spur_q    <= 1'b0;
        end else begin
            en_q      <= en_d;
            pend_q    <= pend_d;
            spu_q     <= spu_d;
            st_q      <= st_d;
            cur_q     <= cur_d;
            normal_irq_out_n_q    <= normal_irq_out_n_d;
            fast_irq_out_n_q    <= fast_irq_out_n_d;
            rd_q      <= (i_ivr_rd | i_fvr_rd) && st_q == VIRQ_IDLE;
            spur_rd_q <= st_q == VIRQ_IDLE && st_d == VIRQ_SPUR;
            // own flop so the status pin carries no decode glitch
            spur_q    <= st_d == VIRQ_SPUR;
        end
    end

    // read data one cycle after the read, from the memory's register, or from spu_q on a spurious read
    assign o_vec_rdata        = spur_rd_q ? spu_q : mem_rd; // [RULE_07]
    assign o_vec_valid        = rd_q;
    assign o_spurious         = spur_q;
    assign o_spu_vec          = spu_q;
    assign o_normal_irq_out_n = normal_irq_out_n_q;
    assign o_fast_irq_out_n   = fast_irq_out_n_q;

    property p_spur_quiet;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        st_q == VIRQ_SPUR |=> o_normal_irq_out_n && o_fast_irq_out_n;
    endproperty
    a_spur_quiet: assert property (p_spur_quiet) // [RULE_05]
        else $error("request asserted during spurious handling");

    property p_empty_read;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        st_q == VIRQ_IDLE && i_ivr_rd && !i_fvr_rd && !any_irq
        |=> o_spurious ##0 o_vec_valid && o_vec_rdata == spu_q;
    endproperty
    a_empty_read: assert property (p_empty_read) // [RULE_03]
        else $error("empty vector read did not go spurious");

    property p_fast_empty;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        st_q == VIRQ_IDLE && i_fvr_rd && !any_fiq |=> o_spurious;
    endproperty
    a_fast_empty: assert property (p_fast_empty) // [RULE_04]
        else $error("empty fast read did not go spurious");

    property p_eoi_clear;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        o_spurious && i_eoi_wr |=> !o_spurious;
    endproperty
    a_eoi_clear: assert property (p_eoi_clear) // [RULE_09]
        else $error("end-of-interrupt did not clear spurious state");

    property p_spur_hold;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        o_spurious && !i_eoi_wr |=> o_spurious;
    endproperty
    a_spur_hold: assert property (p_spur_hold) // [RULE_05]
        else $error("spurious state left without acknowledge");

    property p_spu_write;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        i_spu_wr |=> o_spu_vec == $past(i_vec_data);
    endproperty
    a_spu_write: assert property (p_spu_write) // [RULE_08]
        else $error("spurious vector not stored");

    property p_disabled_read;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        st_q == VIRQ_IDLE && i_ivr_rd && !i_fvr_rd && (pend_q & ~en_q) != '0
        && (act & ~NUM_SRC'(1)) == '0 |=> o_spurious;
    endproperty
    a_disabled_read: assert property (p_disabled_read) // [RULE_02]
        else $error("disabled source read did not go spurious");

    property p_level_drop;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        !o_normal_irq_out_n && i_ivr_rd && !i_fvr_rd && !any_irq
        |=> o_spurious;
    endproperty
    a_level_drop: assert property (p_level_drop) // [RULE_01]
        else $error("withdrawn request not treated as spurious");
endmodule // virq_spu_ctrl

// ==== virq_core_mdl.sv ====
// core model: takes a normal request, reads the vector, acknowledges
`timescale 1ns/100ps
module virq_core_mdl (
    input  wire logic       i_sys_clk,
    input  wire logic       i_arm,
    input  wire logic [3:0] i_lat,
    input  wire logic       i_irq_n,
    input  wire logic       i_vec_valid,
    output logic            o_ivr_rd,
    output logic            o_eoi_wr
);
    logic [3:0] cnt = 4'h0;
    logic       taken = 1'b0;
    logic       waiting = 1'b0;
    logic       done = 1'b0;
    initial o_ivr_rd = 1'b0;
    initial o_eoi_wr = 1'b0;
    // i_lat models a slow handler, so the request can vanish meanwhile
    always @(posedge i_sys_clk) begin
        o_ivr_rd <= 1'b0;
        o_eoi_wr <= 1'b0;
        if (!i_arm) done <= 1'b0;
        if (i_arm && !done && !taken && !waiting && !i_irq_n) begin
            taken <= 1'b1;
            cnt   <= i_lat;
        end else if (taken && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (taken) begin
            o_ivr_rd <= 1'b1;
            taken    <= 1'b0;
            waiting  <= 1'b1;
        end
        if (waiting && i_vec_valid) begin
            o_eoi_wr <= 1'b1; // acknowledge before return
            waiting  <= 1'b0;
            done     <= 1'b1;
        end
    end
endmodule // virq_core_mdl

// ==== spurious_interrupt_handling_tb.sv ====
// self-checking bench for spurious interrupt handling
`timescale 1ns/100ps
module spurious_interrupt_handling_tb;
    import virq_spu_pkg::*;
    logic        clk = 0, rst_b = 0, en = 0, dis = 0, vwr = 0, swr = 0;
    logic        irq_vector_reg = 0, fvr = 0, eoi = 0, arm = 0;
    logic [3:0]  lat = 0;
    logic [31:0] src = 0, msk = 0, vdat = 0, lvl = 32'hffff_ffff;
    wire         m_rd, m_eoi, irq_n, fiq_n, vv, spur;
    wire  [31:0] rdat, spv;
    int          err_total = 0, comparisons = 0;
    localparam logic [31:0] SV = 32'h0000_5a5a;
    always #2.5 clk = ~clk;
    virq_spu_ctrl virq_spu_ctrl_i (.i_sys_clk(clk), .i_rst_b(rst_b),
        .i_src(src), .i_src_level(lvl), .i_enable_wr(en),
        .i_disable_wr(dis), .i_cmd_mask(msk), .i_vec_wr(vwr),
        .i_vec_idx(5'h05), .i_vec_data(vdat), .i_spu_wr(swr),
        .i_ivr_rd(irq_vector_reg | m_rd), .i_fvr_rd(fvr), .i_eoi_wr(eoi | m_eoi),
        .o_normal_irq_out_n(irq_n), .o_fast_irq_out_n(fiq_n),
        .o_vec_rdata(rdat), .o_vec_valid(vv), .o_spurious(spur),
        .o_spu_vec(spv));
    virq_core_mdl virq_core_mdl_i (.i_sys_clk(clk), .i_arm(arm),
        .i_lat(lat), .i_irq_n(irq_n), .i_vec_valid(vv), .o_ivr_rd(m_rd),
        .o_eoi_wr(m_eoi));
    task test_done;
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [39:0] s, input logic [39:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task cy(input int n);
        repeat (n) @(negedge clk);
    endtask
    task cmd(input logic e, input logic d, input logic [31:0] m);
        msk = m;
        en = e;
        dis = d;
        cy(1);
        en = 0;
        dis = 0;
    endtask
    task wvv;
        for (int k = 0; k < 40 && vv !== 1'b1; k++) cy(1);
    endtask
    task wlow(input logic f);
        for (int k = 0; k < 20 && (f ? fiq_n : irq_n) !== 1'b0; k++) cy(1);
    endtask
    task eoi_w;
        eoi = 1;
        cy(1);
        eoi = 0;
        cy(1);
        chk(spur, 0);
        cy(3);
    endtask
    task s_empty;
        irq_vector_reg = 1;
        cy(1);
        irq_vector_reg = 0;
        chk({vv, spur}, 2'b11);
        chk(rdat, SV);
        cmd(1, 0, 32'h20);
        src[5] = 1;
        cy(8);
        chk({irq_n, fiq_n}, 2'b11);
        eoi_w();
        chk(irq_n, 0);
        src[5] = 0;
        cy(8);
    endtask
    task s_normal;
        src[5] = 1;
        arm = 1;
        wvv();
        chk({vv, spur, rdat}, {2'b10, 32'h0000_0105});
        src[5] = 0;
        arm = 0;
        cy(10);
        chk(irq_n, 1);
    endtask
    // slow handler; the request is withdrawn or disabled so that it
    // vanishes in the very cycle in which the core's read lands
    task s_race(input logic d);
        lat = 4'ha;
        src[5] = 1;
        arm = 1;
        wlow(0);
        cy(d ? 11 : 9);
        if (d) cmd(0, 1, 32'h20);
        else src[5] = 0;
        wvv();
        if (d) chk({vv, spur, rdat}, {2'b11, SV});
        else chk({vv, spur, rdat}, {2'b11, SV});
        arm = 0;
        cy(2);
        chk(spur, 0);
        src[5] = 0;
        if (d) cmd(1, 0, 32'h20);
        cy(8);
    endtask
    task s_fast;
        cmd(1, 0, 32'h1);
        src[0] = 1;
        wlow(1);
        chk(fiq_n, 0);
        src[0] = 0;
        cy(6);
        fvr = 1;
        cy(1);
        fvr = 0;
        chk({vv, spur, rdat}, {2'b11, SV});
        src[0] = 1;
        cy(8);
        chk(fiq_n, 1);
        eoi_w();
        chk(fiq_n, 0);
    endtask
    // edge source: the pin pulse is latched, a served read clears it
    task s_edge;
        lvl[5] = 0;
        lat = 0;
        src[5] = 1;
        cy(2);
        src[5] = 0;
        wlow(0);
        cy(3);
        chk(irq_n, 0);
        arm = 1;
        wvv();
        chk({vv, spur, rdat}, {2'b10, 32'h0000_0105});
        arm = 0;
        cy(10);
        chk(irq_n, 1);
    endtask
    initial begin
        cy(5);
        rst_b = 1;
        cy(1);
        chk({irq_n, fiq_n, spur, vv, spv}, {4'b1100, SPU_RST_VAL});
        vdat = SV;
        swr = 1;
        cy(1);
        swr = 0;
        chk(spv, SV);
        vdat = 32'h0000_0105;
        vwr = 1;
        cy(1);
        vwr = 0;
        s_empty();
        s_normal();
        s_race(0);
        s_race(1);
        s_fast();
        s_edge();
        test_done();
    end
    initial begin
        #20000;
        err_total++;
        test_done();
    end
endmodule // spurious_interrupt_handling_tb
